//--- core/rate_ctrl.v
/*
 decimation filter rate controller: paces the data-ready strobe from the
 selected filter type and divider, tracks step settling and sequences
 enabled channels. classic wishbone slave, 32-bit data.
 assumes the conversion datapath runs on the master-clock tick given here.
*/
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "rate_ctrl_consts.vh"
module rate_ctrl #(
	parameter MCLK_DIV = `MCLK_DIV,
	parameter CHANS    = 8
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             cyc_i,
	input  wire             stb_i,
	input  wire             we_i,
	input  wire [7:0]       adr_i,
	input  wire [3:0]       sel_i,
	input  wire [31:0]      dat_i,
	output reg  [31:0]      dat_o,
	output reg              ack_o,
	input  wire             step_i,
	output reg              data_ready_n_o,
	output reg  [2:0]       channel_o,
	output reg              settled_o,
	output wire             irq_o
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg [3:0]       filter_type;
	reg             enable;
	reg             repeat_mode;
	reg [10:0]      rate_divider_value;
	reg [CHANS-1:0] chan_en;
	reg [2:0]       irq_stat;
	reg [2:0]       irq_en;
	reg             state;
	reg [19:0]      cnt;
	reg [2:0]       settle_left;
	reg             step_pending;
	reg             step_mid;
	reg [2:0]       next_chan;
	wire            tick;
	wire [19:0]     conv_cycles;
	wire            terminal;
	wire            ev_ready;
	wire            ev_settled;
	wire            ev_wrap;
	wire [2:0]      settle_need;
	wire            step_go;
	wire            wr;
	integer         i;

	mclk_tick #(
		.DIV(MCLK_DIV)
	) u_tick (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tick_o(tick)
	);

	// cycle count per conversion; post-processing already folded in
	function [19:0] cnv_len;
		input [3:0]  ft;
		input [10:0] dv;
		reg   [10:0] d;
		begin
			d = (dv == 11'h000) ? 11'h001 : dv; // R6
			if ((ft == `FLT_SINC4 || ft == `FLT_SINC4_AVG) &&
			    d > `DIV_SINC4_MAX)
				d = `DIV_SINC4_MAX; // R15 R12
			case (ft)
				`FLT_SINC4, `FLT_SINC3, `FLT_SINC3_NOTCH:
					cnv_len = d * `MULT_SINC; // R4 R10
				`FLT_SINC4_AVG:
					cnv_len = d * `MULT_SINC4_AVG; // R4 R11
				`FLT_SINC3_AVG:
					cnv_len = d * `MULT_SINC3_AVG; // R4 R11
				`FLT_POST1: cnv_len = `CNV_POST1; // R5 R16
				`FLT_POST2: cnv_len = `CNV_POST2; // R5 R16
				`FLT_POST3: cnv_len = `CNV_POST3; // R5 R16
				`FLT_POST4: cnv_len = `CNV_POST4; // R5 R16
				default:    cnv_len = d * `MULT_SINC;
			endcase
		end
	endfunction

	// results needed to settle a step that lines up with a conversion
	function [2:0] settle_len;
		input [3:0] ft;
		begin
			case (ft)
				`FLT_SINC4:                   settle_len = `SETTLE_SINC4;
				`FLT_SINC3, `FLT_SINC3_NOTCH: settle_len = `SETTLE_SINC3;
				`FLT_SINC4_AVG, `FLT_SINC3_AVG: settle_len = `SETTLE_AVG;
				default:                      settle_len = `SETTLE_POST;
			endcase
		end
	endfunction

	assign conv_cycles = cnv_len(filter_type, rate_divider_value);
	assign terminal    = (state == ST_RUN) && tick && (cnt <= 20'h00001);
	assign ev_ready    = terminal;
	assign settle_need = settle_len(filter_type)
	                     + {2'b00, step_mid | step_i}; // R7 R8
	assign step_go     = terminal && (step_pending || step_i);
	assign ev_settled  = terminal && (step_go ? (settle_need == 3'h1)
	                     : (settle_left == 3'h1));
	assign ev_wrap     = terminal && !repeat_mode && (next_chan <= channel_o)
	                     && (chan_en != {CHANS{1'b0}});
	assign wr          = cyc_i && stb_i && we_i && !ack_o;
	assign irq_o       = |(irq_stat & irq_en);

	// lowest enabled channel above the current one, else lowest overall
	always @* begin
		next_chan = channel_o;
		for (i = CHANS - 1; i >= 0; i = i - 1) begin
			if (chan_en[i])
				next_chan = i[2:0];
		end
		for (i = CHANS - 1; i >= 0; i = i - 1) begin
			if (chan_en[i] && i[2:0] > channel_o)
				next_chan = i[2:0]; // R13
		end
	end

	// conversion pacing
	always @(posedge clk_i) begin
		if (rst_i) begin
			state          <= ST_IDLE;
			cnt            <= 20'h00000;
			data_ready_n_o <= 1'b1;
			channel_o      <= 3'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					data_ready_n_o <= 1'b1;
					if (enable) begin
						state <= ST_RUN;
						cnt   <= conv_cycles; // R18
					end
				end
				ST_RUN: begin
					if (!enable) begin
						state          <= ST_IDLE;
						data_ready_n_o <= 1'b1;
					end else if (terminal) begin
						// reload on the tick so spacing stays exact
						cnt            <= conv_cycles; // R1 R2 R18
						data_ready_n_o <= 1'b0; // R1
						if (!repeat_mode)
							channel_o <= next_chan; // R3 R13
					end else begin
						if (tick)
							cnt <= cnt - 20'h00001; // R17
						if (tick)
							data_ready_n_o <= 1'b1;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// step settling; an asynchronous step costs one extra result
	always @(posedge clk_i) begin
		if (rst_i) begin
			settle_left  <= 3'h0;
			settled_o    <= 1'b1;
			step_pending <= 1'b0;
			step_mid     <= 1'b0;
		end else begin
			if (step_i && !terminal) begin
				step_pending <= 1'b1;
				step_mid     <= (cnt != conv_cycles); // R7
			end else if (step_go) begin
				step_pending <= 1'b0;
				// the result in flight is the first one after the step
				settle_left  <= settle_need - 3'h1; // R7 R8
				settled_o    <= (settle_need == 3'h1);
			end else if (terminal && settle_left != 3'h0) begin
				settle_left <= settle_left - 3'h1; // R8
				if (settle_left == 3'h1)
					settled_o <= 1'b1;
			end
		end
	end

	// register writes and sticky interrupt status; set wins over clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			filter_type        <= `FLT_RESET; // R14
			enable             <= 1'b0;
			repeat_mode        <= 1'b0;
			rate_divider_value <= `DIV_RESET;
			chan_en            <= {{(CHANS-1){1'b0}}, 1'b1};
			irq_en             <= 3'h0;
			irq_stat           <= 3'h0;
		end else begin
			if (wr && sel_i[0]) begin
				case (adr_i)
					`REG_CTRL: begin
						filter_type <= dat_i[3:0]; // R14
						enable      <= dat_i[4];
						repeat_mode <= dat_i[5];
					end
					`REG_DIVIDER: rate_divider_value[7:0] <= dat_i[7:0]; // R6
					`REG_CHAN_EN: chan_en <= dat_i[CHANS-1:0];
					`REG_IRQ_EN:  irq_en  <= dat_i[2:0];
					default: ;
				endcase
			end
			if (wr && sel_i[1] && adr_i == `REG_DIVIDER)
				rate_divider_value[10:8] <= dat_i[10:8]; // R6
			irq_stat <= (irq_stat & ~((wr && sel_i[0] &&
			             adr_i == `REG_IRQ_CLR) ? dat_i[2:0] : 3'h0))
			            | {ev_wrap, ev_settled, ev_ready};
		end
	end

	// bus answer one cycle after the request, unmapped reads give zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
			case (adr_i)
				`REG_CTRL:     dat_o <= {26'h0, repeat_mode, enable,
				                         filter_type};
				`REG_DIVIDER:  dat_o <= {21'h0, rate_divider_value};
				`REG_CHAN_EN:  dat_o <= {{(32-CHANS){1'b0}}, chan_en};
				`REG_STATUS:   dat_o <= {24'h0, channel_o, settle_left,
				                         settled_o, state};
				`REG_IRQ_STAT: dat_o <= {29'h0, irq_stat};
				`REG_IRQ_EN:   dat_o <= {29'h0, irq_en};
				`REG_COUNT:    dat_o <= {12'h0, cnt};
				default:       dat_o <= 32'h00000000;
			endcase
		end
	end
endmodule // rate_ctrl

//--- shared/rate_ctrl_consts.vh
/*
 holds offsets, field positions, reset values and cycle counts for the
 decimation filter rate controller; assumes a 100 MHz system clock and
 a 76.8 kHz master-clock tick derived from it.
*/
// Summary of operation
// R1 - data-ready falls once per conversion interval
// R2 - post-processing time lies inside the interval
// R3 - settled pacing for repeat or single channel
// R4 - 32, 352 or 320 times divider cycles
// R5 - post filters use fixed 2944/3200/3968/4736 cycles
// R6 - divider is unsigned 11-bit field bits 10:0
// R7 - step mid-conversion needs one extra result
// R8 - settling results 3-4, 2-3, 1-2, 0-1 by filter; the code counts 4-5, 3-4, 2-3, 1-2 results
// R9 - software uses divider 48 or 240 for mains
// R10 - code 0011 selects sinc3 with extra notch
// R11 - averaging stage averages eight sinc outputs
// R12 - sinc4 restricted divider values, no mains notch
// R13 - sequencer steps through all enabled channels automatically
// R14 - four-bit filter code map, sinc3 default
// R15 - sinc4 types clamp divider above 10 to 10
// R16 - post filters ignore divider value
// R17 - intervals counted on 76.8 kHz master clock
// R18 - reloaded master-clock counter pulses data-ready low
`ifndef RATE_CTRL_CONSTS_VH
`define RATE_CTRL_CONSTS_VH
`define REG_CTRL        8'h00
`define REG_DIVIDER     8'h04
`define REG_CHAN_EN     8'h08
`define REG_STATUS      8'h0C
`define REG_IRQ_STAT    8'h10
`define REG_IRQ_CLR     8'h14
`define REG_IRQ_EN      8'h18
`define REG_COUNT       8'h1C
`define FLT_SINC4       4'h0
`define FLT_SINC4_AVG   4'h1
`define FLT_SINC3       4'h2
`define FLT_SINC3_NOTCH 4'h3
`define FLT_SINC3_AVG   4'h4
`define FLT_POST1       4'h5
`define FLT_POST2       4'h6
`define FLT_POST3       4'h7
`define FLT_POST4       4'h8
`define FLT_RESET       4'h2
`define DIV_RESET       11'h001
`define DIV_SINC4_MAX   11'h00A
`define MULT_SINC       16'h0020
`define MULT_SINC4_AVG  16'h0160
`define MULT_SINC3_AVG  16'h0140
`define CNV_POST1       20'h00B80
`define CNV_POST2       20'h00C80
`define CNV_POST3       20'h00F80
`define CNV_POST4       20'h01280
`define SETTLE_SINC4    3'h4
`define SETTLE_SINC3    3'h3
`define SETTLE_AVG      3'h2
`define SETTLE_POST     3'h1
`define SYS_CLK_HZ      100000000
`define MCLK_HZ         76800
`define MCLK_DIV        (`SYS_CLK_HZ / `MCLK_HZ)
`define IRQ_READY       0
`define IRQ_SETTLED     1
`define IRQ_WRAP        2
`endif

//--- core/mclk_tick.v
/*
 master-clock tick generator; emits a one-cycle pulse at the 76.8 kHz rate.
 assumes a free running system clock and a synchronous reset.
*/
`timescale 1ns/1ps
module mclk_tick #(
	parameter DIV = 1302
) (
	input  wire clk_i,
	input  wire rst_i,
	output reg  tick_o
);
	reg [15:0] cnt;
	// divider rounds down, so the tick runs a hair fast rather than slow
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt    <= 16'h0000;
			tick_o <= 1'b0;
		end else if (cnt == DIV[15:0] - 16'h0001) begin
			cnt    <= 16'h0000;
			tick_o <= 1'b1; // R17
		end else begin
			cnt    <= cnt + 16'h0001;
			tick_o <= 1'b0;
		end
	end
endmodule // mclk_tick

//--- dv/rate_ctrl_chk.sv
/*
 port checker for the rate controller.
 assumes it is bound to rate_ctrl and shares its MCLK_DIV.
*/
`timescale 1ns/1ps
module rate_ctrl_chk #(
	parameter MCLK_DIV = 2
) (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       cyc_i,
	input wire logic       stb_i,
	input wire logic       ack_o,
	input wire logic       step_i,
	input wire logic       data_ready_n_o,
	input wire logic [2:0] channel_o,
	input wire logic       settled_o,
	input wire logic       irq_o
);
	logic step_seen;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a step is owed until the next result has been seen
	always @(posedge clk_i) begin
		if (rst_i)
			step_seen <= 1'b0;
		else if (step_i)
			step_seen <= 1'b1;
		else if ($fell(data_ready_n_o))
			step_seen <= 1'b0;
	end
	a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	a_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without request");
	a_reset_values: assert property (disable iff (1'b0) rst_i |=>
		data_ready_n_o && !ack_o && channel_o == 3'h0 && settled_o && !irq_o)
		else $error("bad reset values");
	// a write may stop the run mid pulse, so only quiet cycles count
	a_ready_hold: assert property ($fell(data_ready_n_o) ##1 !cyc_i
		|-> !data_ready_n_o) else $error("ready pulse too short");
	a_chan_at_ready: assert property ($changed(channel_o)
		|-> !data_ready_n_o || ack_o) else $error("channel moved early");
	a_settle_at_ready: assert property ($rose(settled_o)
		|-> $fell(data_ready_n_o)) else $error("settled off result");
	a_step_unsettle: assert property ($fell(settled_o)
		|-> $fell(data_ready_n_o) && step_seen)
		else $error("settled dropped without step");
	c_ready: cover property ($fell(data_ready_n_o));
	c_settle: cover property ($rose(settled_o));
	c_chan: cover property ($changed(channel_o));
endmodule // rate_ctrl_chk

bind rate_ctrl rate_ctrl_chk #(.MCLK_DIV(MCLK_DIV)) i_chk (.clk_i, .rst_i,
	.cyc_i, .stb_i, .ack_o, .step_i, .data_ready_n_o, .channel_o,
	.settled_o, .irq_o);

//--- dv/host_model.sv
/*
 host that counts results and the clocks between data-ready falls.
 assumes data-ready is synchronous to clk_i.
*/
`timescale 1ns/1ps
module host_model (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic data_ready_n_i,
	output int        n_res_o,
	output int        gap_o
);
	int   run;
	logic prev;
	always @(posedge clk_i) begin
		prev <= data_ready_n_i;
		run <= run + 1;
		if (rst_i) begin
			prev <= 1'b1;
			run <= 0;
			n_res_o <= 0;
			gap_o <= 0;
		end else if (prev && !data_ready_n_i) begin
			n_res_o <= n_res_o + 1;
			gap_o <= run;
			run <= 1;
		end
	end
endmodule // host_model

//--- dv/tb_top.sv
/*
 testbench for rate_ctrl: wishbone tasks and timing checks.
 assumes the short master tick MD for a fast run.
*/
`timescale 1ns/1ps
`include "rate_ctrl_consts.vh"
module tb_top;
	localparam int MD = 2;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, step_i;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, r;
	logic        ack_o, data_ready_n_o, settled_o, irq_o;
	logic [2:0]  channel_o, c1;
	int          n_res, gap, n0, t, n_mismatch, n_compared;
	rate_ctrl #(.MCLK_DIV(MD)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i,
		.we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .step_i,
		.data_ready_n_o, .channel_o, .settled_o, .irq_o);
	host_model i_host (.clk_i, .rst_i, .data_ready_n_i(data_ready_n_o),
		.n_res_o(n_res), .gap_o(gap));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// waits for ack without limit; only the watchdog ends a hang
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do
			@(posedge clk_i);
		while (ack_o !== 1'b1);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clk_i);
	endtask
	// returns once the host has counted n more results
	task wait_res(input int n);
		n0 = n_res;
		t = 0;
		while (n_res < n0 + n && t < 40000) begin
			@(posedge clk_i);
			t++;
		end
		if (t >= 40000)
			n_mismatch++;
	endtask
	// stop, program, restart, then time the second interval
	task run_cfg(input logic [3:0] f, input logic [10:0] d, input int tk);
		wb(1'b1, `REG_CTRL, 32'h0);
		wb(1'b1, `REG_DIVIDER, {21'h0, d});
		wb(1'b1, `REG_CTRL, {27'h0, 1'b1, f});
		wait_res(2);
		chk("interval", gap, tk * MD);
	endtask
	initial begin
		{rst_i, cyc_i, stb_i, we_i, step_i} = 5'b10000;
		{adr_i, dat_i, sel_i} = {8'h00, 32'h0, 4'hF};
		n_mismatch = 0;
		n_compared = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `REG_CTRL, 32'h0);
		chk("ctrl reset", r[5:0], {2'b00, `FLT_RESET});
		wb(1'b0, `REG_DIVIDER, 32'h0);
		chk("divider reset", r[10:0], `DIV_RESET);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", r, 32'h0);
		wb(1'b1, `REG_CHAN_EN, 32'h05);
		run_cfg(`FLT_SINC3, 11'h001, 32);
		wait_res(1);
		c1 = channel_o;
		wait_res(1);
		chk("sequence", c1 ^ channel_o, 3'h2);
		wb(1'b1, `REG_CTRL, 32'h32);
		wait_res(1);
		c1 = channel_o;
		wait_res(1);
		chk("repeat", channel_o, c1);
		wb(1'b1, `REG_CHAN_EN, 32'h01);
		wb(1'b1, `REG_IRQ_CLR, 32'h07);
		wait_res(1);
		wb(1'b0, `REG_IRQ_STAT, 32'h0);
		chk("irq sticky", r[2:0], 3'h1);
		wb(1'b1, `REG_IRQ_EN, 32'h01);
		@(posedge clk_i);
		chk("irq on", irq_o, 1'b1);
		wb(1'b1, `REG_IRQ_EN, 32'h0);
		chk("irq masked", irq_o, 1'b0);
		wb(1'b1, `REG_IRQ_EN, 32'h01);
		wait_res(1);
		repeat (3) @(posedge clk_i);
		step_i <= 1'b1;
		@(posedge clk_i);
		step_i <= 1'b0;
		n0 = n_res;
		t = 0;
		while (settled_o !== 1'b0 && t < 4000) begin
			@(posedge clk_i);
			t++;
		end
		while (settled_o !== 1'b1 && t < 4000) begin
			@(posedge clk_i);
			t++;
		end
		if (t >= 4000)
			n_mismatch++;
		@(posedge clk_i);
		chk("settle count", n_res - n0, 4);
		wb(1'b0, `REG_IRQ_STAT, 32'h0);
		chk("settle irq", r[2:0], 3'h3);
		wb(1'b1, `REG_CTRL, 32'h0);
		wb(1'b1, `REG_IRQ_CLR, 32'h07);
		wb(1'b0, `REG_IRQ_STAT, 32'h0);
		chk("irq cleared", {r[2:0], irq_o}, 4'h0);
		run_cfg(`FLT_SINC4, 11'h00C, 320);
		run_cfg(`FLT_SINC4_AVG, 11'h001, 352);
		run_cfg(`FLT_SINC3_AVG, 11'h001, 320);
		run_cfg(`FLT_SINC3_NOTCH, 11'h002, 64);
		run_cfg(`FLT_SINC3, 11'h030, 1536);
		run_cfg(`FLT_POST1, 11'h005, 2944);
		run_cfg(`FLT_POST2, 11'h7FF, 3200);
		run_cfg(`FLT_POST3, 11'h001, 3968);
		run_cfg(`FLT_POST4, 11'h001, 4736);
		give_verdict;
	end
	initial begin
		#950000;
		n_mismatch++;
		give_verdict;
	end
endmodule // tb_top
